// *** shared/lpm_pkg.sv ***
package lpm_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_IOCTL = 8'h04;
	localparam logic [7:0] ADDR_CPUCTL = 8'h08;
	localparam logic [7:0] ADDR_IRQEN = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_SAVED = 8'h14;
	localparam int IO_HALT_POS = 5;
	localparam int CCR_B3_POS = 3;
	localparam int CCR_B6_POS = 6;
	localparam int CTRL_HALT_POS = 0;
	localparam int CTRL_SLEEP_POS = 1;
	localparam int CTRL_GIE_POS = 2;
	localparam int IRQ_SRC_N = 5;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	localparam logic [19:0] ADDR_ONES = 20'hFFFFF;
	// Restart delay: 1.5 clocks rounded up to whole cycles
	localparam real RESTART_CLK = 1.5;
	localparam int RESTART_CYC = (RESTART_CLK > 2.0) ? 3 : 2;
	localparam logic [1:0] RESTART_CNT = 2'(RESTART_CYC);
	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_HALT = 5'h02,
		ST_SLEEP = 5'h04,
		ST_SYSSTOP = 5'h08,
		ST_WAKE = 5'h10
	} lpm_state_t;
endpackage : lpm_pkg

// *** core/lpm_ctrl.sv ***
module lpm_ctrl
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic nmi_req,
	input wire logic ext_irq_line0,
	input wire logic ext_irq_line1,
	input wire logic ext_irq_line2,
	input wire logic onchip_irq,
	input wire logic onchip_irq_io,
	input wire logic bus_granted,
	input wire logic [15:0] fetch_pc,
	output logic halt_n,
	output logic status_strobe,
	output logic opcode_fetch_cycle_n,
	output logic cpu_clk_en,
	output logic dma_clk_en,
	output logic refresh_en,
	output logic io_clk_en,
	output logic irq_take,
	output logic cpu_exec_en,
	output logic hold_bus_high,
	output logic [19:0] addr_out,
	output logic [15:0] saved_ret
);
	import lpm_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [5:0] pin_s1_q;
	logic [5:0] pin_s2_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else begin
			pin_s1_q <= {bus_granted, onchip_irq_io, ext_irq_line2, ext_irq_line1,
				ext_irq_line0, nmi_req};
			pin_s2_q <= pin_s1_q;
		end
	end

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	logic ph_wr_q;
	logic ph_rd_q;
	logic [7:0] ph_addr_q;
	logic [7:0] ctrl_q;
	logic [7:0] ioctl_q;
	logic [7:0] cpuctl_q;
	logic [IRQ_SRC_N-1:0] irqen_q;
	lpm_state_t state_q;
	logic [1:0] wake_cnt_q;
	logic [15:0] ret_q;
	logic take_q;
	wire logic acc = hsel && hready && (htrans == HTRANS_NONSEQ);
	wire logic wr_ctrl = ph_wr_q && (ph_addr_q == ADDR_CTRL);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr_q <= 1'b0;
			ph_rd_q <= 1'b0;
			ph_addr_q <= '0;
		end else begin
			ph_wr_q <= acc && hwrite;
			ph_rd_q <= acc && !hwrite;
			ph_addr_q <= haddr[7:0];
		end
	end

	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		unique case (a)
			ADDR_CTRL: rd_mux = {24'h000000, ctrl_q};
			ADDR_IOCTL: rd_mux = {24'h000000, ioctl_q};
			ADDR_CPUCTL: rd_mux = {24'h000000, cpuctl_q};
			ADDR_IRQEN: rd_mux = {27'h0000000, irqen_q};
			ADDR_STATUS: rd_mux = {27'h0000000, state_q};
			ADDR_SAVED: rd_mux = {16'h0000, ret_q};
			default: rd_mux = ZERO32;
		endcase
	endfunction : rd_mux

	// Read data is registered: answer one cycle after the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= ZERO32;
		end else if (acc && !hwrite) begin
			hrdata <= rd_mux(haddr[7:0]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ioctl_q <= '0;
			cpuctl_q <= '0;
			irqen_q <= '0;
		end else if (ph_wr_q) begin
			// I/O stop bit changes only by software write or reset
			if (ph_addr_q == ADDR_IOCTL) ioctl_q <= hwdata[7:0];
			if (ph_addr_q == ADDR_CPUCTL) cpuctl_q <= hwdata[7:0];
			if (ph_addr_q == ADDR_IRQEN) irqen_q <= hwdata[IRQ_SRC_N-1:0];
		end
	end

	// Instruction bits are one-shot; global enable bit is a level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= '0;
		end else if (wr_ctrl) begin
			ctrl_q <= hwdata[7:0];
		end else begin
			ctrl_q[CTRL_HALT_POS] <= 1'b0;
			ctrl_q[CTRL_SLEEP_POS] <= 1'b0;
		end
	end

	// ****************************************
	// Wake decode
	// ****************************************
	wire logic io_halt_bit = ioctl_q[IO_HALT_POS];
	wire logic global_irq_enable_flag = ctrl_q[CTRL_GIE_POS];
	wire logic nmi_s = pin_s2_q[0];
	wire logic [2:0] ext_s = pin_s2_q[3:1];
	wire logic io_irq_s = pin_s2_q[4];
	wire logic grant_s = pin_s2_q[5];
	// Enables: bit0 on-chip core irq, bit1 on-chip I/O irq, bits 4:2 external
	wire logic ext_wake = |(ext_s & irqen_q[4:2]);
	wire logic chip_wake = onchip_irq && irqen_q[0];
	// Sources stopped by I/O stop cannot wake
	wire logic io_wake = io_irq_s && irqen_q[1] && !io_halt_bit;
	wire logic any_wake = nmi_s || ext_wake || chip_wake || io_wake;
	wire logic sleep_ok = !io_halt_bit && !cpuctl_q[CCR_B3_POS] && !cpuctl_q[CCR_B6_POS];

	// ****************************************
	// Mode state machine
	// ****************************************
	// I/O stop is the io_halt_bit level in run; together with states gives five modes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_RUN;
			wake_cnt_q <= '0;
			take_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_RUN: begin
					take_q <= 1'b0;
					if (wr_ctrl && hwdata[CTRL_HALT_POS]) begin
						state_q <= ST_HALT;
					end else if (wr_ctrl && hwdata[CTRL_SLEEP_POS]) begin
						if (sleep_ok) state_q <= ST_SLEEP;
						else if (io_halt_bit) state_q <= ST_SYSSTOP;
					end
				end
				ST_HALT: begin
					if (any_wake) begin
						state_q <= ST_RUN;
						take_q <= 1'b1;
					end
				end
				ST_SLEEP, ST_SYSSTOP: begin
					if (any_wake) begin
						state_q <= ST_WAKE;
						wake_cnt_q <= RESTART_CNT;
						take_q <= global_irq_enable_flag || nmi_s;
					end
				end
				ST_WAKE: begin
					wake_cnt_q <= wake_cnt_q - 2'h1;
					if (wake_cnt_q == 2'h1) state_q <= ST_RUN;
				end
			endcase
		end
	end

	// Return address captured at wake: instruction after halt/sleep
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ret_q <= '0;
		end else if ((state_q != ST_RUN) && (state_q != ST_WAKE) && any_wake) begin
			ret_q <= fetch_pc;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	wire logic is_halt = (state_q == ST_HALT);
	wire logic is_sleepish = (state_q == ST_SLEEP) || (state_q == ST_SYSSTOP);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			halt_n <= 1'b1;
			status_strobe <= 1'b1;
			opcode_fetch_cycle_n <= 1'b1;
			cpu_clk_en <= 1'b1;
			dma_clk_en <= 1'b1;
			refresh_en <= 1'b1;
			io_clk_en <= 1'b1;
			irq_take <= 1'b0;
			cpu_exec_en <= 1'b1;
			hold_bus_high <= 1'b0;
			addr_out <= '0;
			saved_ret <= '0;
		end else begin
			halt_n <= !(is_halt || is_sleepish);
			// In halt strobes low; in sleep controls held high
			status_strobe <= !is_halt;
			opcode_fetch_cycle_n <= !is_halt;
			cpu_clk_en <= !is_sleepish && (state_q != ST_WAKE);
			dma_clk_en <= !is_sleepish;
			refresh_en <= !is_sleepish;
			io_clk_en <= !io_halt_bit;
			irq_take <= take_q && (state_q == ST_RUN);
			cpu_exec_en <= (state_q == ST_RUN);
			hold_bus_high <= is_sleepish && !grant_s;
			addr_out <= (is_sleepish && !grant_s) ? ADDR_ONES : {4'h0, fetch_pc};
			saved_ret <= ret_q;
		end
	end

	// ****************************************
	// Checks: mode entry
	// ****************************************
	halt_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == ST_RUN && wr_ctrl && hwdata[CTRL_HALT_POS] |=> state_q == ST_HALT)
		else $error("halt not entered");

	exec_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
		is_halt |=> !cpu_exec_en)
		else $error("core executes in halt");

	sleep_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == ST_RUN && $past(state_q) == ST_RUN && !sleep_ok |=> state_q != ST_SLEEP)
		else $error("sleep entered while blocked");

	sleep_accept_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == ST_RUN && wr_ctrl && hwdata[CTRL_SLEEP_POS] && !hwdata[CTRL_HALT_POS]
		&& sleep_ok |=> state_q == ST_SLEEP)
		else $error("sleep not entered");

	sys_stop_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == ST_RUN && wr_ctrl && hwdata[CTRL_SLEEP_POS] && !hwdata[CTRL_HALT_POS]
		&& io_halt_bit |=> state_q == ST_SYSSTOP)
		else $error("system stop not entered");

	io_bit_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!ph_wr_q |=> $stable(io_halt_bit))
		else $error("I/O stop bit changed without write");

	// ****************************************
	// Checks: wake
	// ****************************************
	halt_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
		is_halt && any_wake |=> state_q == ST_RUN)
		else $error("halt not left on wake");

	halt_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		is_halt && !any_wake |=> state_q == ST_HALT)
		else $error("halt left without source");

	halt_take_a: assert property (@(posedge hclk) disable iff (!hresetn)
		is_halt && any_wake |=> ##1 irq_take)
		else $error("no interrupt response after halt");

	halt_ret_a: assert property (@(posedge hclk) disable iff (!hresetn)
		is_halt && any_wake |=> ret_q == $past(fetch_pc))
		else $error("halt return address wrong");

	no_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
		is_sleepish && !any_wake |=> state_q == $past(state_q))
		else $error("woke without source");

	nmi_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
		is_sleepish && nmi_s |=> state_q == ST_WAKE)
		else $error("non-maskable request did not wake");

	sys_stop_io_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == ST_SYSSTOP && io_halt_bit && !nmi_s && !ext_wake && !chip_wake
		|=> state_q == ST_SYSSTOP)
		else $error("stopped I/O source woke system stop");

	restart_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
		is_sleepish && any_wake |=> state_q == ST_WAKE ##2 state_q == ST_RUN)
		else $error("restart delay wrong");

	gie_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		is_sleepish && any_wake && !global_irq_enable_flag && !nmi_s |=> ##3 !irq_take)
		else $error("interrupt taken with flag clear");

	gie_set_take_a: assert property (@(posedge hclk) disable iff (!hresetn)
		is_sleepish && any_wake && global_irq_enable_flag |=> ##3 irq_take)
		else $error("interrupt not taken with flag set");

	sleep_ret_a: assert property (@(posedge hclk) disable iff (!hresetn)
		is_sleepish && any_wake |=> ret_q == $past(fetch_pc))
		else $error("sleep return address wrong");

	// ****************************************
	// Checks: pins and clocks
	// ****************************************
	halt_pins_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(state_q) == ST_HALT |-> !halt_n && !status_strobe && !opcode_fetch_cycle_n)
		else $error("halt pins not low");

	run_halt_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == ST_RUN && $past(state_q) == ST_RUN |=> halt_n)
		else $error("halt indicator low in run");

	halt_clocks_a: assert property (@(posedge hclk) disable iff (!hresetn)
		is_halt |=> cpu_clk_en && dma_clk_en && refresh_en)
		else $error("clocks stopped in halt");

	sleep_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == ST_SLEEP |=> !cpu_clk_en && !dma_clk_en && !refresh_en)
		else $error("sleep clocks not gated");

	grant_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
		is_sleepish && grant_s |=> !hold_bus_high && !refresh_en)
		else $error("bus held while granted");

	sleep_bus_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		is_sleepish && !grant_s |=> hold_bus_high && !halt_n && addr_out == ADDR_ONES)
		else $error("bus not held high in sleep");

	sleep_io_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == ST_SLEEP && !io_halt_bit |=> io_clk_en && !dma_clk_en)
		else $error("I/O stopped in sleep");

	io_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
		io_halt_bit |=> !io_clk_en)
		else $error("I/O clock not stopped");

	io_resume_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!io_halt_bit |=> io_clk_en)
		else $error("I/O clock not resumed");

	sys_stop_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == ST_SYSSTOP && io_halt_bit |=> !cpu_clk_en && !io_clk_en && !halt_n)
		else $error("system stop clocks not gated");
endmodule : lpm_ctrl

// *** dv/lpm_core_model.sv ***
module lpm_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic cpu_exec_en,
	output logic [15:0] fetch_pc
);
	timeunit 1ns;
	timeprecision 100ps;
	// The core only steps to the next opcode while it executes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fetch_pc <= 16'h0100;
		end else if (cpu_exec_en) begin
			fetch_pc <= fetch_pc + 16'h0001;
		end
	end
endmodule : lpm_core_model

// *** dv/lpm_ctrl_tb_top.sv ***
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module lpm_ctrl_tb_top import lpm_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, nmi_req = 0, bus_granted = 0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = ZERO32, hwdata = ZERO32, hrdata, e;
	logic [4:0] src = 5'h00;
	logic hreadyout, hresp, halt_n, status_strobe, opcode_fetch_cycle_n, cpu_clk_en;
	logic dma_clk_en, refresh_en, io_clk_en, irq_take, cpu_exec_en, hold_bus_high;
	logic dph = 0;
	logic [19:0] addr_out;
	logic [15:0] saved_ret, fetch_pc, pc;
	logic [31:0] q[$];
	int mismatches = 0, comparisons = 0, takes = 0, t0;
	always #12.5 hclk = ~hclk;
	lpm_ctrl lpm_ctrl_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .nmi_req,
		.ext_irq_line0(src[2]), .ext_irq_line1(src[3]), .ext_irq_line2(src[4]),
		.onchip_irq(src[0]), .onchip_irq_io(src[1]), .bus_granted, .fetch_pc, .halt_n,
		.status_strobe, .opcode_fetch_cycle_n, .cpu_clk_en, .dma_clk_en, .refresh_en,
		.io_clk_en, .irq_take, .cpu_exec_en, .hold_bus_high, .addr_out, .saved_ret);
	lpm_core_model lpm_core_model_i (.hclk, .hresetn, .cpu_exec_en, .fetch_pc);
	// ****
	// Read data watcher
	// ****
	always @(posedge hclk) begin
		if (irq_take === 1'b1) takes <= takes + 1;
		if (dph && hreadyout === 1'b1) begin
			e = q.pop_front();
			`CHK({hresp, hrdata}, {1'b0, e})
		end
		if (hreadyout) dph <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
	end
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h000000, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		if (!w) q.push_back(d);
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
	endtask : bus
	task cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc
	task conclude();
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (6000) @(posedge hclk);
		mismatches++;
		conclude();
	end
	// ****
	// Scenarios
	// ****
	initial begin
		void'($urandom(32'hE8CE));
		cyc(8);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(0, ADDR_STATUS, 32'h1);
		`CHK({halt_n, io_clk_en, cpu_exec_en}, 3'h7)
		bus(0, 8'h40, ZERO32);
		bus(1, ADDR_IRQEN, ZERO32);
		bus(1, ADDR_CTRL, 32'h1);
		cyc(3);
		pc = fetch_pc;
		`CHK(addr_out, {4'h0, pc})
		`CHK({halt_n, status_strobe, opcode_fetch_cycle_n, cpu_exec_en}, 4'h0)
		`CHK({dma_clk_en, refresh_en, io_clk_en, cpu_clk_en}, 4'hF)
		src <= 5'h04;
		cyc(6);
		bus(0, ADDR_STATUS, 32'h2);
		src <= 5'h00;
		nmi_req <= 1'b1;
		cyc(6);
		nmi_req <= 1'b0;
		`CHK(saved_ret, pc)
		bus(0, ADDR_STATUS, 32'h1);
		for (int b = 3; b <= 6; b += 3) begin
			bus(1, ADDR_CPUCTL, 32'h1 << b);
			bus(1, ADDR_CTRL, 32'h2);
			cyc(2);
			bus(0, ADDR_STATUS, 32'h1);
		end
		bus(1, ADDR_CPUCTL, ZERO32);
		for (int k = 0; k < 10; k++) begin
			bus(1, ADDR_IRQEN, ZERO32);
			bus(1, ADDR_CTRL, 32'h2 | 32'((k / 5) << CTRL_GIE_POS));
			cyc(3);
			`CHK({cpu_clk_en, dma_clk_en, refresh_en, io_clk_en}, 4'h1)
			`CHK({halt_n, hold_bus_high, addr_out}, {2'h1, ADDR_ONES})
			bus_granted <= 1'b1;
			cyc(4);
			`CHK(hold_bus_high, 1'b0)
			bus_granted <= 1'b0;
			src <= (5'h01 << (k % 5)) | 5'($urandom);
			cyc(4 + $urandom % 4);
			bus(0, ADDR_STATUS, 32'h4);
			t0 = takes;
			bus(1, ADDR_IRQEN, 32'h1 << (k % 5));
			cyc(8);
			`CHK(takes != t0, k >= 5)
			`CHK(cpu_exec_en, 1'b1)
			src <= 5'h00;
			bus(0, ADDR_STATUS, 32'h1);
		end
		bus(1, ADDR_IOCTL, 32'h1 << IO_HALT_POS);
		cyc(2);
		`CHK({io_clk_en, cpu_exec_en}, 2'h1)
		bus(1, ADDR_IRQEN, 32'h6);
		bus(1, ADDR_CTRL, 32'h2);
		src <= 5'h02;
		cyc(6);
		bus(0, ADDR_STATUS, 32'h8);
		`CHK(cpu_clk_en, 1'b0)
		src <= 5'h04;
		cyc(8);
		bus(0, ADDR_STATUS, 32'h1);
		`CHK(io_clk_en, 1'b0)
		src <= 5'h00;
		bus(1, ADDR_IOCTL, ZERO32);
		cyc(2);
		`CHK(io_clk_en, 1'b1)
		bus(1, ADDR_IOCTL, 32'h1 << IO_HALT_POS);
		hresetn <= 1'b0;
		cyc(2);
		hresetn <= 1'b1;
		cyc(1);
		bus(0, ADDR_IOCTL, ZERO32);
		conclude();
	end
endmodule : lpm_ctrl_tb_top
